/* File: ppcs_cfg.svh */
/*
 Offsets, field positions, reset values and counts of the PHY port
 control and status register slice.
 Assumes it is included by bare name after the package.
*/
`ifndef PPCS_CFG_SVH
`define PPCS_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PPCS_IDX_P1_CTRL_A 8'h1c
`define PPCS_IDX_P1_CTRL_B 8'h1d
`define PPCS_IDX_P1_STAT_A 8'h1e
`define PPCS_IDX_P2_CTRL_A 8'h2c
`define PPCS_IDX_P2_CTRL_B 8'h2d
`define PPCS_IDX_P2_STAT_A 8'h2e
`define PPCS_IDX_IRQ_STAT  8'h40
`define PPCS_IDX_IRQ_CLR   8'h41
`define PPCS_IDX_IRQ_EN    8'h42

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PPCS_CTRL_A_RST    2'h3
`define PPCS_CTRL_B_RST    8'h00
`define PPCS_BIT_RESTART   5
`define PPCS_BIT_XOVER     7
`define PPCS_BIT_AN_DONE   6
`define PPCS_IRQ_W         4
`define PPCS_STRAP_WAIT    2'h2
`define PPCS_LED_BLANK     4'hf

`endif

/* File: ppcs_phy_model.sv */
/*
 Behavioural PHY core seen from the register slice: negotiation
 completion, crossover result and normal LED levels per port.
 Assumes the slice clock and reset; crossover result is steered by the bench.
*/
`timescale 1ns/10ps

module ppcs_phy_model
   import ppcs_pkg::*;
#(
   parameter int AN_WAIT = 6
)
(
   // Clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rst,
   // From the register slice
   input  wire ppcs_phy_out_type [1:0] i_phy,
   // Crossover result wanted by the bench
   input  wire logic [1:0]             i_mdix_req,
   // To the register slice
   output      ppcs_phy_in_type  [1:0] o_phy
);
   int cnt [2];

   // ----------------------------------------------------------------
   // Negotiation: restart drops completion, it returns after a wait
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk or posedge i_rst) begin
      for (int p = 0; p < 2; p++) begin
         if (i_rst) begin
            cnt[p] <= AN_WAIT;
            o_phy[p] <= '0;
         end else begin
            o_phy[p].auto_mdix <= i_mdix_req[p];
            o_phy[p].led <= p[0] ? 4'ha : 4'h5;
            if (i_phy[p].an_restart) begin
               cnt[p] <= AN_WAIT;
               o_phy[p].an_done <= 1'b0;
            end else if (cnt[p] > 0) begin
               cnt[p] <= cnt[p] - 1;
               o_phy[p].an_done <= (cnt[p] == 1);
            end
         end
      end
   end
endmodule

/* File: ppcs_pkg.sv */
/*
 Types of the PHY port control and status register slice.
 Assumes nothing of its surroundings.
*/
package ppcs_pkg;

   // ----------------------------------------------------------------
   // Register layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic led_off;
      logic tx_dis;
      logic an_restart;
      logic fef_dis;
      logic pwr_dn;
      logic mdix_dis;
      logic force_mdi;
      logic loopback;
   } ppcs_ctrl_b_type;

   typedef struct packed {
      logic adv_10_fd;
      logic adv_10_hd;
   } ppcs_ctrl_a_type;

   // ----------------------------------------------------------------
   // Bus and PHY carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ppcs_apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ppcs_apb_rsp_type;

   typedef struct packed {
      logic       an_done;
      logic       auto_mdix;
      logic [3:0] led;
   } ppcs_phy_in_type;

   typedef struct packed {
      logic       adv_10_fd;
      logic       adv_10_hd;
      logic       tx_dis;
      logic       an_restart;
      logic       fef_dis;
      logic       pwr_dn;
      logic       use_mdix;
      logic       loopback;
      logic [3:0] port_indicator_out;
   } ppcs_phy_out_type;

endpackage

/* File: ppcs_regs.sv */
/*
 APB register slice for the two PHY ports: advertisement bits,
 second control register, crossover and negotiation status, and
 an interrupt block for status events.
 Assumes a same-clock PHY core on i_phy/o_phy and an APB master;
 the crossover strap is an asynchronous pin.
*/
// Notes on behaviour
// - 10BT full-duplex advertise bit, default one
// - 10BT half-duplex advertise bit, default one
// - LED blanking drives all four indicators high
// - Transmitter disable bit stops line drive
// - Writing restart bit starts new negotiation
// - Far-end fault disable, first port only
// - Crossover-auto disable turns off auto MDI-X
// - Second port disable resets from strap
// - Force bit: one MDI, zero MDI-X
// - First port loopback bit loops first port
// - Second port loopback bit loops second port
// - Negotiation done status reads completion
`timescale 1ns/10ps
`include "ppcs_cfg.svh"

module ppcs_regs
   import ppcs_pkg::*;
(
   // Clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rst,
   // Register bus
   input  wire ppcs_apb_req_type       i_apb,
   output      ppcs_apb_rsp_type       o_apb,
   // Strap pin
   input  wire logic                   i_second_port_crossover_strap,
   // PHY core
   input  wire ppcs_phy_in_type  [1:0] i_phy,
   output      ppcs_phy_out_type [1:0] o_phy,
   // Interrupt
   output      logic                   o_irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ppcs_ctrl_a_type  [1:0] ctrl_a;
      ppcs_ctrl_b_type  [1:0] ctrl_b;
      logic             [1:0] xover;
      logic             [1:0] an_done;
      logic             [3:0] irq_st;
      logic             [3:0] irq_en;
      logic             [1:0] strap_sync;
      logic             [1:0] init_cnt;
      logic                   init_done;
      logic            [31:0] prdata;
      logic                   pslverr;
      ppcs_phy_out_type [1:0] phy;
   } ppcs_state_type;

   ppcs_state_type s_r;
   ppcs_state_type s_nxt;

   logic        setup;
   logic        access;
   logic        wr_hit;
   logic [7:0]  idx;
   logic        addr_ok;
   logic [31:0] rd;
   logic        hit;
   logic [1:0]  mdix_now;
   logic [3:0]  ev;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign setup   = i_apb.psel & ~i_apb.penable;
   assign access  = i_apb.psel & i_apb.penable;
   assign idx     = i_apb.paddr[9:2];
   // Upper address bits and byte lanes must be zero or the access is refused
   assign addr_ok = (i_apb.paddr[11:10] == 2'h0) & (i_apb.paddr[1:0] == 2'h0);
   assign wr_hit  = access & i_apb.pwrite & hit;

   always_comb begin
      rd  = 32'h0;
      hit = addr_ok;
      if (idx == `PPCS_IDX_P1_CTRL_A) begin
         rd[1:0] = s_r.ctrl_a[0];
      end else if (idx == `PPCS_IDX_P2_CTRL_A) begin
         rd[1:0] = s_r.ctrl_a[1];
      end else if (idx == `PPCS_IDX_P1_CTRL_B) begin
         // Restart is a strobe; a read right after the write must not see it
         rd[7:0] = s_r.ctrl_b[0];
         rd[`PPCS_BIT_RESTART] = 1'b0;
      end else if (idx == `PPCS_IDX_P2_CTRL_B) begin
         rd[7:0] = s_r.ctrl_b[1];
         rd[`PPCS_BIT_RESTART] = 1'b0;
      end else if (idx == `PPCS_IDX_P1_STAT_A) begin
         rd[`PPCS_BIT_XOVER]   = s_r.xover[0];
         rd[`PPCS_BIT_AN_DONE] = s_r.an_done[0];
      end else if (idx == `PPCS_IDX_P2_STAT_A) begin
         rd[`PPCS_BIT_XOVER]   = s_r.xover[1];
         rd[`PPCS_BIT_AN_DONE] = s_r.an_done[1];
      end else if (idx == `PPCS_IDX_IRQ_STAT) begin
         rd[3:0] = s_r.irq_st;
      end else if (idx == `PPCS_IDX_IRQ_EN) begin
         rd[3:0] = s_r.irq_en;
      end else if (idx == `PPCS_IDX_IRQ_CLR) begin
         rd = 32'h0;
      end else begin
         hit = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Crossover state the PHY should run in
   // ----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         if (s_r.ctrl_b[p].mdix_dis) begin
            mdix_now[p] = ~s_r.ctrl_b[p].force_mdi;
         end else begin
            mdix_now[p] = i_phy[p].auto_mdix;
         end
      end
   end

   // Events: negotiation completed, crossover state changed
   assign ev = {mdix_now[1] ^ s_r.xover[1],
                mdix_now[0] ^ s_r.xover[0],
                i_phy[1].an_done & ~s_r.an_done[1],
                i_phy[0].an_done & ~s_r.an_done[0]};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      // Raw pin: two flops before anything reads it
      s_nxt.strap_sync = {s_r.strap_sync[0], i_second_port_crossover_strap};
      // Reset cannot load a pin, so the strap is taken once it is synced
      if (!s_r.init_done) begin
         if (s_r.init_cnt == `PPCS_STRAP_WAIT) begin
            s_nxt.ctrl_b[1].mdix_dis = s_r.strap_sync[1];
            s_nxt.init_done = 1'b1;
         end else begin
            s_nxt.init_cnt = s_r.init_cnt + 2'h1;
         end
      end
      if (setup) begin
         s_nxt.prdata  = rd;
         s_nxt.pslverr = ~hit;
      end
      // Restart bit stays set for one cycle only; it only makes a pulse
      for (int p = 0; p < 2; p++) begin
         s_nxt.ctrl_b[p].an_restart = 1'b0;
      end
      if (wr_hit) begin
         if (idx == `PPCS_IDX_P1_CTRL_A) begin
            s_nxt.ctrl_a[0] = i_apb.pwdata[1:0];
         end else if (idx == `PPCS_IDX_P2_CTRL_A) begin
            s_nxt.ctrl_a[1] = i_apb.pwdata[1:0];
         end else if (idx == `PPCS_IDX_P1_CTRL_B) begin
            s_nxt.ctrl_b[0] = i_apb.pwdata[7:0];
         end else if (idx == `PPCS_IDX_P2_CTRL_B) begin
            s_nxt.ctrl_b[1] = i_apb.pwdata[7:0];
         end else if (idx == `PPCS_IDX_IRQ_EN) begin
            s_nxt.irq_en = i_apb.pwdata[3:0];
         end
      end
      // Set wins over clear so no event is lost
      if (wr_hit && idx == `PPCS_IDX_IRQ_CLR) begin
         s_nxt.irq_st = (s_r.irq_st & ~i_apb.pwdata[3:0]) | ev;
      end else begin
         s_nxt.irq_st = s_r.irq_st | ev;
      end
      s_nxt.xover   = mdix_now;
      s_nxt.an_done = {i_phy[1].an_done, i_phy[0].an_done};
      for (int p = 0; p < 2; p++) begin
         s_nxt.phy[p].adv_10_fd  = s_r.ctrl_a[p].adv_10_fd;
         s_nxt.phy[p].adv_10_hd  = s_r.ctrl_a[p].adv_10_hd;
         s_nxt.phy[p].tx_dis     = s_r.ctrl_b[p].tx_dis;
         s_nxt.phy[p].an_restart = s_r.ctrl_b[p].an_restart;
         s_nxt.phy[p].pwr_dn     = s_r.ctrl_b[p].pwr_dn;
         s_nxt.phy[p].use_mdix   = mdix_now[p];
         s_nxt.phy[p].loopback   = s_r.ctrl_b[p].loopback;
         if (s_r.ctrl_b[p].led_off) begin
            s_nxt.phy[p].port_indicator_out = `PPCS_LED_BLANK;
         end else begin
            s_nxt.phy[p].port_indicator_out = i_phy[p].led;
         end
      end
      // Only the first port has a fiber path
      s_nxt.phy[0].fef_dis = s_r.ctrl_b[0].fef_dis;
      s_nxt.phy[1].fef_dis = 1'b0;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r <= '0;
         for (int p = 0; p < 2; p++) begin
            s_r.ctrl_a[p] <= `PPCS_CTRL_A_RST;
            s_r.ctrl_b[p] <= `PPCS_CTRL_B_RST;
            s_r.phy[p].adv_10_fd <= 1'b1;
            s_r.phy[p].adv_10_hd <= 1'b1;
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Zero-wait slave; read data was caught in the setup cycle
   assign o_apb.pready  = 1'b1;
   assign o_apb.pslverr = s_r.pslverr;
   assign o_apb.prdata  = s_r.prdata;
   // Level output; software clears the cause, not the line
   assign o_irq         = |(s_r.irq_st & s_r.irq_en);

   generate
      for (genvar g = 0; g < 2; g++) begin : g_port
         assign o_phy[g] = s_r.phy[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   generate
      for (genvar g = 0; g < 2; g++) begin : g_chk
         led_blank_a: assert property (
            s_r.ctrl_b[g].led_off |=> o_phy[g].port_indicator_out == 4'hf)
            else $error("LED blanking not applied");
         tx_dis_a: assert property (
            s_r.ctrl_b[g].tx_dis |=> o_phy[g].tx_dis)
            else $error("Transmitter disable not applied");
         pwr_dn_a: assert property (
            o_phy[g].pwr_dn == $past(s_r.ctrl_b[g].pwr_dn))
            else $error("Power-down does not follow control");
         force_mdi_a: assert property (
            s_r.ctrl_b[g].mdix_dis |=> o_phy[g].use_mdix == !$past(s_r.ctrl_b[g].force_mdi))
            else $error("Forced crossover not applied");
         auto_mdix_a: assert property (
            !s_r.ctrl_b[g].mdix_dis |=> o_phy[g].use_mdix == $past(i_phy[g].auto_mdix))
            else $error("Automatic crossover not followed");
         xover_stat_a: assert property (
            ##1 s_r.xover[g] == o_phy[g].use_mdix)
            else $error("Crossover status differs from mode");
         adv_fd_a: assert property (
            o_phy[g].adv_10_fd == $past(s_r.ctrl_a[g].adv_10_fd))
            else $error("Full-duplex advertise not applied");
         loop_a: assert property (
            s_r.ctrl_b[g].loopback |=> o_phy[g].loopback)
            else $error("Loopback not applied");
         adv_hd_a: assert property (
            o_phy[g].adv_10_hd == $past(s_r.ctrl_a[g].adv_10_hd))
            else $error("Half-duplex advertise not applied");
         led_normal_a: assert property (
            !s_r.ctrl_b[g].led_off |=> o_phy[g].port_indicator_out == $past(i_phy[g].led))
            else $error("LED levels not passed through");
         tx_en_a: assert property (
            !s_r.ctrl_b[g].tx_dis |=> !o_phy[g].tx_dis)
            else $error("Transmitter held off");
         loop_off_a: assert property (
            !s_r.ctrl_b[g].loopback |=> !o_phy[g].loopback)
            else $error("Loopback left on");
         restart_once_a: assert property (
            o_phy[g].an_restart |=> !o_phy[g].an_restart)
            else $error("Restart pulse longer than one cycle");
         an_stat_a: assert property (
            s_r.an_done[g] == $past(i_phy[g].an_done))
            else $error("Negotiation done status lags");
         // Bus view: what software writes and reads back
         ctrl_a_wr_a: assert property (
            wr_hit && idx == (g == 0 ? `PPCS_IDX_P1_CTRL_A : `PPCS_IDX_P2_CTRL_A)
            |=> s_r.ctrl_a[g] == $past(i_apb.pwdata[1:0]))
            else $error("Advertise write not stored");
         ctrl_wr_a: assert property (
            wr_hit && idx == (g == 0 ? `PPCS_IDX_P1_CTRL_B : `PPCS_IDX_P2_CTRL_B)
            |=> s_r.ctrl_b[g].led_off == $past(i_apb.pwdata[7]))
            else $error("LED blanking write not stored");
         restart_read_a: assert property (
            setup && addr_ok && idx == (g == 0 ? `PPCS_IDX_P1_CTRL_B : `PPCS_IDX_P2_CTRL_B)
            |=> !o_apb.prdata[`PPCS_BIT_RESTART])
            else $error("Restart bit reads back as one");
         xover_read_a: assert property (
            setup && addr_ok && idx == (g == 0 ? `PPCS_IDX_P1_STAT_A : `PPCS_IDX_P2_STAT_A)
            |=> o_apb.prdata[`PPCS_BIT_XOVER] == $past(s_r.xover[g]))
            else $error("Crossover status read wrong");
         an_read_a: assert property (
            setup && addr_ok && idx == (g == 0 ? `PPCS_IDX_P1_STAT_A : `PPCS_IDX_P2_STAT_A)
            |=> o_apb.prdata[`PPCS_BIT_AN_DONE] == $past(s_r.an_done[g]))
            else $error("Negotiation done read wrong");
      end
   endgenerate

   restart_a: assert property (
      wr_hit && idx == `PPCS_IDX_P1_CTRL_B && i_apb.pwdata[`PPCS_BIT_RESTART]
      |=> ##1 o_phy[0].an_restart ##1 !o_phy[0].an_restart)
      else $error("Restart pulse missing");
   fef_port2_a: assert property (
      !o_phy[1].fef_dis)
      else $error("Far-end fault disable on second port");
   strap_load_a: assert property (
      $rose(s_r.init_done) |-> s_r.ctrl_b[1].mdix_dis == $past(s_r.strap_sync[1]))
      else $error("Strap not loaded");
   an_done_a: assert property (
      $rose(i_phy[0].an_done) |=> s_r.an_done[0] && s_r.irq_st[0])
      else $error("Negotiation done not reported");
   fef_port1_a: assert property (
      o_phy[0].fef_dis == $past(s_r.ctrl_b[0].fef_dis))
      else $error("Far-end fault disable not applied");
   restart_p2_a: assert property (
      wr_hit && idx == `PPCS_IDX_P2_CTRL_B && i_apb.pwdata[`PPCS_BIT_RESTART]
      |=> ##1 o_phy[1].an_restart ##1 !o_phy[1].an_restart)
      else $error("Restart pulse missing on second port");
   irq_set_a: assert property (
      ev != 4'h0 |=> (s_r.irq_st & $past(ev)) == $past(ev))
      else $error("Status event lost");
   irq_clear_a: assert property (
      wr_hit && idx == `PPCS_IDX_IRQ_CLR && ev == 4'h0
      |=> (s_r.irq_st & $past(i_apb.pwdata[3:0])) == 4'h0)
      else $error("Status bit not cleared");

   // ----------------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------------
   restart_c: cover property (o_phy[0].an_restart);
   clr_set_c: cover property (wr_hit && idx == `PPCS_IDX_IRQ_CLR && ev != 4'h0);
   loop_c: cover property (o_phy[1].loopback && o_phy[0].loopback);
   irq_c: cover property (o_irq ##1 !o_irq);
   strap_c: cover property ($rose(s_r.init_done) && s_r.strap_sync[1]);

endmodule

/* File: ppcs_regs_tb_top.sv */
/*
 Self-checking bench of the PHY port register slice.
 Assumes the slice and the behavioural PHY core model; APB is zero wait.
*/
`timescale 1ns/10ps
`include "ppcs_cfg.svh"

module ppcs_regs_tb_top;
   import ppcs_pkg::*;
   logic                   clk;
   logic                   rst;
   logic                   strap;
   logic [1:0]             mdix_req;
   ppcs_apb_req_type       apb_q;
   ppcs_apb_rsp_type       apb_rsp;
   ppcs_phy_in_type  [1:0] phy_in;
   ppcs_phy_out_type [1:0] phy_out;
   logic                   irq;
   int                     n_mismatch;
   int                     comparisons;
   integer                 seed;
   logic [31:0]            rd;
   logic                   err;
   logic [7:0]             v;
   logic [7:0]             ca_idx [2];
   logic [7:0]             cb_idx [2];
   logic [7:0]             st_idx [2];

   ppcs_regs dut_u (.i_sys_clk(clk), .i_rst(rst), .i_apb(apb_q), .o_apb(apb_rsp),
      .i_second_port_crossover_strap(strap), .i_phy(phy_in), .o_phy(phy_out), .o_irq(irq));
   ppcs_phy_model phy_u (.i_sys_clk(clk), .i_rst(rst), .i_phy(phy_out), .i_mdix_req(mdix_req),
      .o_phy(phy_in));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One idle edge first, so a release never meets a new setup
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk);
      apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
      @(posedge clk);
      apb_q.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_q.psel <= 1'b0;
      apb_q.penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
      chk(32'(err), 32'h0);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic exp_mdix(input logic [7:0] cb, input logic auto);
      return cb[2] ? ~cb[1] : auto;
   endfunction

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      #(25 * 20000);
      n_mismatch++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      comparisons = 0;
      seed = 91;
      rst = 1'b1;
      strap = 1'b1;
      mdix_req = 2'h0;
      apb_q = '0;
      ca_idx = '{`PPCS_IDX_P1_CTRL_A, `PPCS_IDX_P2_CTRL_A};
      cb_idx = '{`PPCS_IDX_P1_CTRL_B, `PPCS_IDX_P2_CTRL_B};
      st_idx = '{`PPCS_IDX_P1_STAT_A, `PPCS_IDX_P2_STAT_A};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      settle(4);
      chk(32'({phy_out[0].adv_10_fd, phy_out[1].adv_10_hd}), 32'h3);
      rdchk(ca_idx[0], 32'h3);
      rdchk(cb_idx[0], 32'h0);
      rdchk(cb_idx[1], 32'h4);
      // Random control words on both ports, restart bit kept clear here
      for (int i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         v[5] = 1'b0;
         mdix_req <= 2'($random(seed));
         apb(1'b1, cb_idx[i%2], {24'h0, v});
         apb(1'b1, ca_idx[i%2], {30'h0, v[7:6]});
         settle(3);
         chk(32'(phy_out[i%2].port_indicator_out), v[7] ? 32'hf : ((i%2) ? 32'ha : 32'h5));
         chk(32'(phy_out[i%2].tx_dis), 32'(v[6]));
         chk(32'(phy_out[i%2].fef_dis), (i%2) ? 32'h0 : 32'(v[4]));
         chk(32'(phy_out[i%2].pwr_dn), 32'(v[3]));
         chk(32'(phy_out[i%2].use_mdix), 32'(exp_mdix(v, mdix_req[i%2])));
         chk(32'(phy_out[i%2].loopback), 32'(v[0]));
         chk(32'({phy_out[i%2].adv_10_fd, phy_out[i%2].adv_10_hd}), 32'(v[7:6]));
         rdchk(cb_idx[i%2], {24'h0, v});
         rdchk(st_idx[i%2], {24'h0, exp_mdix(v, mdix_req[i%2]), 7'h40});
      end
      // Restart on each port: only port one's completion is enabled
      // Both ports parked in forced MDI-X first, so no crossover event spoils the status
      apb(1'b1, cb_idx[0], 32'h04);
      apb(1'b1, cb_idx[1], 32'h04);
      apb(1'b1, `PPCS_IDX_IRQ_CLR, 32'hf);
      apb(1'b1, `PPCS_IDX_IRQ_EN, 32'h1);
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, cb_idx[p], 32'h24);
         settle(1);
         chk(32'(phy_out[p].an_restart), 32'h1);
         settle(1);
         chk(32'(phy_out[p].an_restart), 32'h0);
         rdchk(st_idx[p], 32'h80);
         rdchk(cb_idx[p], 32'h04);
         settle(12);
         chk(32'(irq), 32'(p == 0));
         rdchk(`PPCS_IDX_IRQ_STAT, 32'(1 << p));
         rdchk(st_idx[p], 32'hc0);
         apb(1'b1, `PPCS_IDX_IRQ_CLR, 32'hf);
         settle(2);
         chk(32'(irq), 32'h0);
      end
      // Unmapped place is refused and reads zero
      apb(1'b0, 8'h50, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      // Second reset with the strap low: port two comes up with auto crossover
      strap <= 1'b0;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      settle(4);
      chk(32'({phy_out[1].adv_10_fd, phy_out[1].adv_10_hd}), 32'h3);
      rdchk(cb_idx[1], 32'h0);
      rdchk(ca_idx[1], 32'h3);
      summarize();
   end
endmodule
